// ===== common/swie_pkg.sv
package swie_pkg;

    localparam int unsigned REG_AW = 6;
    localparam int unsigned REG_DW = 24;

    // Register offsets
    localparam logic [5:0] EDGE_SEL_HIGH_OFS = 6'h23;
    localparam logic [5:0] FAULT_EN_OFS      = 6'h24;

    // Reset values
    localparam logic [23:0] EDGE_SEL_RST = 24'h000000;
    localparam logic [11:0] FAULT_EN_RST = 12'h000;

    // Edge-select field encoding
    localparam logic [1:0] EDGE_NONE    = 2'h0;
    localparam logic [1:0] EDGE_RISING  = 2'h1;
    localparam logic [1:0] EDGE_FALLING = 2'h2;
    localparam logic [1:0] EDGE_BOTH    = 2'h3;

    // Edge-select field layout
    localparam int unsigned FIRST_INPUT   = 12;
    localparam int unsigned NUM_INPUTS    = 8;
    localparam int unsigned FIELD_W       = 2;
    localparam int unsigned GROUP4_FIRST  = 16;

    // Fault-enable bit positions
    localparam int unsigned FE_SERIAL_FRAME = 0;
    localparam int unsigned FE_PARITY       = 1;
    localparam int unsigned FE_SWITCH_SHORT = 2;
    localparam int unsigned FE_THERM_SHUT   = 3;
    localparam int unsigned FE_THERM_WARN   = 4;
    localparam int unsigned FE_SUPPLY_HIGH  = 5;
    localparam int unsigned FE_UNDERVOLT    = 6;
    localparam int unsigned FE_CHECKSUM     = 7;
    localparam int unsigned FE_SUPPLY_A     = 8;
    localparam int unsigned FE_SUPPLY_B     = 9;
    localparam int unsigned FE_WETTING      = 10;
    localparam int unsigned FE_CONVERTER    = 11;
    localparam int unsigned FE_W            = 12;

    // Synchroniser depth
    localparam int unsigned SYNC_STAGES = 2;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [23:0] wdata;
    } swie_req_t;

    typedef struct packed {
        logic        converter_error;
        logic        wetting_error;
        logic        supply_monitor_b;
        logic        supply_monitor_a;
        logic        checksum_done;
        logic        undervoltage;
        logic        supply_high;
        logic        thermal_warning;
        logic        thermal_shutdown;
        logic        switch_short;
        logic        parity_error;
        logic        serial_frame_error;
    } swie_fault_t;

endpackage

// ===== verilog/swie_sync.sv
`timescale 1ns/1ps
module swie_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule

// ===== verilog/swie_irq_enable.sv
`timescale 1ns/1ps
module swie_irq_enable (
    input  wire logic                   core_clk_in,
    input  wire logic                   rstn_in,
    input  wire swie_pkg::swie_req_t    reg_req_in,
    output logic [23:0]                 reg_rdata_out,
    output logic                        reg_rvalid_out,
    input  wire logic [7:0]             comp_level_in,
    input  wire swie_pkg::swie_fault_t  fault_event_in,
    output logic                        irq_out,
    output logic [7:0]                  comp_state_out
);

    localparam int unsigned N  = swie_pkg::NUM_INPUTS;
    localparam int unsigned FW = swie_pkg::FIELD_W;
    localparam int unsigned NF = swie_pkg::FE_W;

    // Two-flop synchronisers for the comparator outputs and fault events
    logic [N-1:0]  comp_sync;
    logic [NF-1:0] fault_sync;

    swie_sync #(.WIDTH(N)) u_comp_sync (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .async_in    (comp_level_in),
        .sync_out    (comp_sync)
    );

    swie_sync #(.WIDTH(NF)) u_fault_sync (
        .core_clk_in (core_clk_in),
        .rstn_in     (rstn_in),
        .async_in    (fault_event_in),
        .sync_out    (fault_sync)
    );

    // Decides whether a given edge-select code fires on this transition
    function automatic logic edge_hit(input logic [1:0] sel,
                                      input logic       prev,
                                      input logic       cur);
        logic rise;
        logic fall;
        rise = !prev && cur;
        fall = prev && !cur;
        case (sel)
            swie_pkg::EDGE_RISING:  edge_hit = rise;
            swie_pkg::EDGE_FALLING: edge_hit = fall;
            swie_pkg::EDGE_BOTH:    edge_hit = rise || fall;
            default:                edge_hit = 1'b0;
        endcase
    endfunction

    function automatic logic addr_is(input logic [5:0] a,
                                     input logic [5:0] ofs);
        addr_is = (a == ofs);
    endfunction

    logic [23:0]   edge_sel_q;
    logic [23:0]   edge_sel_d;
    logic [NF-1:0] fault_en_q;
    logic [NF-1:0] fault_en_d;
    logic [N-1:0]  comp_prev_q;
    logic          irq_q;
    logic          irq_d;
    logic [23:0]   rdata_q;
    logic [23:0]   rdata_d;
    logic          rvalid_q;

    // Register decode
    wire sel_edge  = addr_is(reg_req_in.addr, swie_pkg::EDGE_SEL_HIGH_OFS);
    wire sel_fault = addr_is(reg_req_in.addr, swie_pkg::FAULT_EN_OFS);
    wire wr_edge   = reg_req_in.wr && sel_edge;
    wire wr_fault  = reg_req_in.wr && sel_fault;

    assign edge_sel_d = wr_edge ? reg_req_in.wdata : edge_sel_q;
    // Upper bits dropped so reserved field stays zero
    assign fault_en_d = wr_fault ? reg_req_in.wdata[NF-1:0]
                                 : fault_en_q;

    assign rdata_d = sel_edge  ? edge_sel_q :
                     sel_fault ? {12'h000, fault_en_q} :
                                 24'h000000;

    // Per-input edge detection; comp_sync bit k is already the result of
    // comparing input 12+k with its group threshold (group3 for k<4)
    logic [N-1:0] edge_fire;
    genvar gi;
    generate
        for (gi = 0; gi < N; gi++) begin : g_edge
            wire in_group4 = (swie_pkg::FIRST_INPUT + gi)
                             >= swie_pkg::GROUP4_FIRST;
            assign edge_fire[gi] =
                edge_hit(edge_sel_q[gi*FW +: FW],
                         comp_prev_q[gi], comp_sync[gi]);
        end
    endgenerate

    wire [NF-1:0] fault_fire = fault_sync & fault_en_q;
    assign irq_d = (|edge_fire) || (|fault_fire);

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            edge_sel_q  <= swie_pkg::EDGE_SEL_RST;
            fault_en_q  <= swie_pkg::FAULT_EN_RST;
            comp_prev_q <= '0;
            irq_q       <= 1'b0;
            rdata_q     <= 24'h000000;
            rvalid_q    <= 1'b0;
        end else begin
            edge_sel_q  <= edge_sel_d;
            fault_en_q  <= fault_en_d;
            comp_prev_q <= comp_sync;
            irq_q       <= irq_d;
            rdata_q     <= rdata_d;
            rvalid_q    <= reg_req_in.rd;
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign reg_rvalid_out = rvalid_q;
    assign irq_out        = irq_q;
    assign comp_state_out = comp_prev_q;

    // Assertions
    chk_fault_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        ((fault_sync & fault_en_q) != '0) |=> irq_out)
        else $error("enabled fault did not raise interrupt");

    chk_fault_block: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edge_fire == '0 && (fault_sync & fault_en_q) == '0)
        |=> !irq_out)
        else $error("interrupt raised without enabled cause");

    chk_reserved_zero: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        reg_req_in.rd && sel_fault |=> reg_rdata_out[23:12] == 12'h000)
        else $error("reserved bits not zero");

    chk_fault_reset: assert property (
        @(posedge core_clk_in)
        $rose(rstn_in) |-> fault_en_q == '0 && edge_sel_q == '0)
        else $error("enables not cleared by reset");

    chk_sel_zero: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[1:0] == swie_pkg::EDGE_NONE |-> !edge_fire[0])
        else $error("input 12 fired while disabled");

    chk_rise_only: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[1:0] == swie_pkg::EDGE_RISING && comp_prev_q[0]
        && !comp_sync[0] |-> !edge_fire[0])
        else $error("rising mode fired on fall");

    chk_fall_only: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[3:2] == swie_pkg::EDGE_FALLING && comp_prev_q[1]
        && !comp_sync[1] |-> edge_fire[1] ##1 irq_out)
        else $error("falling edge missed");

    chk_both_edges: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[15:14] == swie_pkg::EDGE_BOTH
        && (comp_prev_q[7] != comp_sync[7]) |=> irq_out)
        else $error("both-edge mode missed crossing");

    chk_write_edge: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        wr_edge |=> edge_sel_q == $past(reg_req_in.wdata))
        else $error("edge select write lost");

    // Steps of multi-cycle behaviours
    sequence s_rd_req;
        reg_req_in.rd;
    endsequence

    sequence s_rd_ans;
        reg_rvalid_out;
    endsequence

    sequence s_wr_fault;
        wr_fault;
    endsequence

    sequence s_rise_12;
        !comp_prev_q[0] && comp_sync[0];
    endsequence

    sequence s_fall_12;
        comp_prev_q[0] && !comp_sync[0];
    endsequence

    // Read answer one cycle after the request
    chk_read_answer: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_rd_req |=> s_rd_ans)
        else $error("read not answered");

    chk_no_stray_valid: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !reg_req_in.rd |=> !reg_rvalid_out)
        else $error("read valid without request");

    chk_fault_write: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        s_wr_fault |=> fault_en_q == $past(reg_req_in.wdata[NF-1:0]))
        else $error("fault enable write lost");

    chk_fault_hold: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !wr_fault |=> $stable(fault_en_q))
        else $error("fault enable changed without write");

    chk_edge_hold: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        !wr_edge |=> $stable(edge_sel_q))
        else $error("edge select changed without write");

    chk_rise_fires: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edge_sel_q[1:0] == swie_pkg::EDGE_RISING) ##0 s_rise_12
        |=> irq_out)
        else $error("rising edge missed");

    chk_fall_quiet: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edge_sel_q[1:0] == swie_pkg::EDGE_FALLING) ##0 s_rise_12
        |-> !edge_fire[0])
        else $error("falling mode fired on rise");

    chk_both_fall: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        (edge_sel_q[1:0] == swie_pkg::EDGE_BOTH) ##0 s_fall_12
        |=> irq_out)
        else $error("both-edge mode missed fall");

    // Last input of the lower group and first of the upper group
    chk_group3_fire: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[7:6] == swie_pkg::EDGE_BOTH
        && (comp_prev_q[3] != comp_sync[3]) |=> irq_out)
        else $error("input 15 crossing missed");

    chk_group4_fire: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[9:8] == swie_pkg::EDGE_BOTH
        && (comp_prev_q[4] != comp_sync[4]) |=> irq_out)
        else $error("input 16 crossing missed");

    chk_in19_rise: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        edge_sel_q[15:14] == swie_pkg::EDGE_RISING
        && !comp_prev_q[7] && comp_sync[7] |=> irq_out)
        else $error("input 19 rise missed");

    chk_wetting_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_WETTING]
        && fault_en_q[swie_pkg::FE_WETTING] |=> irq_out)
        else $error("wetting error not signalled");

    chk_supply_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_SUPPLY_B]
        && fault_en_q[swie_pkg::FE_SUPPLY_B] |=> irq_out)
        else $error("supply crossing not signalled");

    chk_checksum_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_CHECKSUM]
        && fault_en_q[swie_pkg::FE_CHECKSUM] |=> irq_out)
        else $error("checksum completion not signalled");

    chk_voltage_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_UNDERVOLT]
        && fault_en_q[swie_pkg::FE_UNDERVOLT] |=> irq_out)
        else $error("undervoltage not signalled");

    chk_thermal_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_THERM_SHUT]
        && fault_en_q[swie_pkg::FE_THERM_SHUT] |=> irq_out)
        else $error("thermal shutdown not signalled");

    chk_short_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_SWITCH_SHORT]
        && fault_en_q[swie_pkg::FE_SWITCH_SHORT] |=> irq_out)
        else $error("switch short not signalled");

    chk_parity_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_PARITY]
        && fault_en_q[swie_pkg::FE_PARITY] |=> irq_out)
        else $error("parity error not signalled");

    chk_frame_gate: assert property (
        @(posedge core_clk_in) disable iff (!rstn_in)
        fault_sync[swie_pkg::FE_SERIAL_FRAME]
        && fault_en_q[swie_pkg::FE_SERIAL_FRAME] |=> irq_out)
        else $error("frame error not signalled");

endmodule

// ===== tb/swie_host.sv
`timescale 1ns/1ps
module swie_host (
    input  wire logic           core_clk_in,
    output swie_pkg::swie_req_t req_out
);
    initial req_out = '0;

    // One register access: held one cycle, then address and data scrambled
    task automatic xfer(input logic w, input logic [5:0] a,
                        input logic [23:0] d);
        @(negedge core_clk_in);
        req_out = {w, ~w, a, d};
        @(negedge core_clk_in);
        req_out = {2'h0, ~a, ~d};
    endtask
endmodule

// ===== tb/switch_irq_enable_logic_tb.sv
`timescale 1ns/1ps
module switch_irq_enable_logic_tb;
    logic                  core_clk_in = 1'b0;
    logic                  rstn_in     = 1'b0;
    logic [7:0]            comp_level  = 8'h00;
    swie_pkg::swie_fault_t fault_ev    = '0;
    swie_pkg::swie_req_t   req;
    logic [23:0]           rdata;
    logic                  rvalid;
    logic                  irq;
    logic [7:0]            cstate;
    logic [23:0]           exp_q[$];
    int                    n_mismatch  = 0;
    int                    compares    = 0;
    int                    hits;
    logic [23:0]           val;

    always #10 core_clk_in = ~core_clk_in;

    swie_host host (.core_clk_in(core_clk_in), .req_out(req));

    swie_irq_enable uut (
        .core_clk_in    (core_clk_in),
        .rstn_in        (rstn_in),
        .reg_req_in     (req),
        .reg_rdata_out  (rdata),
        .reg_rvalid_out (rvalid),
        .comp_level_in  (comp_level),
        .fault_event_in (fault_ev),
        .irq_out        (irq),
        .comp_state_out (cstate)
    );

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 24'h0);
    endtask

    task automatic irq_hits(input int n);
        hits = 0;
        repeat (n) begin
            @(negedge core_clk_in);
            hits += (irq === 1'b1);
        end
    endtask

    task automatic results();
        n_mismatch += exp_q.size();
        if (n_mismatch == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Read results checked against the oldest expectation
    always @(negedge core_clk_in) begin
        if (rvalid === 1'b1) begin
            if (exp_q.size() > 0)
                cmp(rdata, exp_q.pop_front());
            else begin
                compares++;
                n_mismatch++;
                $display("ERROR t=%0t got=%h exp=%h", $time, rdata, 24'h0);
            end
        end
    end

    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_mismatch++;
        results();
    end

    initial begin
        val = $urandom(23);
        repeat (16) @(negedge core_clk_in);
        rstn_in = 1'b1;
        rd(6'h24, 24'h000000);
        rd(6'h23, 24'h000000);
        host.xfer(1'b1, 6'h24, 24'hffffff);
        rd(6'h24, 24'h000fff);
        rd(6'h10, 24'h000000);
        val = 24'($urandom());
        host.xfer(1'b1, 6'h23, val);
        rd(6'h23, val);
        for (int i = 0; i < 12; i++) begin
            host.xfer(1'b1, 6'h24, 24'h1 << i);
            fault_ev = ~(12'h1 << i);
            irq_hits(4);
            cmp(24'(hits), 24'h0);
            fault_ev = '1;
            irq_hits(4);
            cmp({23'h0, irq}, 24'h1);
            fault_ev = '0;
        end
        host.xfer(1'b1, 6'h24, 24'h0);
        for (int k = 0; k < 8; k++) begin
            for (int m = 0; m < 4; m++) begin
                host.xfer(1'b1, 6'h23, 24'(m) << (2 * k));
                comp_level = ~(8'h1 << k);
                irq_hits(6);
                cmp(24'(hits), 24'h0);
                comp_level = 8'hff;
                irq_hits(6);
                cmp(24'(hits), 24'(m & 1));
                cmp({16'h0, cstate}, 24'h0000ff);
                comp_level = 8'h00;
                irq_hits(6);
                cmp(24'(hits), 24'(m >> 1));
            end
        end
        repeat (4) @(negedge core_clk_in);
        results();
    end
endmodule
